// ===== shared/sink_driver_consts.svh
// Constants for the serial latched sink driver
`ifndef SINK_DRIVER_CONSTS_SVH
`define SINK_DRIVER_CONSTS_SVH
`define SD_STAGES      8
`define SD_LAST_STAGE  7
`define SD_RESET_BYTE  8'h00
`define SD_FIFO_WIDTH  8
`define SD_FIFO_DEPTH  8
`define SD_SYNC_RESET  3'h0
`define SD_OEN_SYNC_RESET 3'h7
`define SD_CHANNELS    8
`endif

// ===== shared/sink_driver_pkg.sv
// Types shared by the sink driver files
package sink_driver_pkg;
  typedef logic [7:0] byte_t;
endpackage : sink_driver_pkg

// ===== rtl/latch_fifo.sv
// Parameterised valid/ready FIFO carrying latched bytes
`timescale 1ns/100ps
`default_nettype none
module latch_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys,   // System clock
  input  wire logic             reset_n,   // Sync reset, active low
  input  wire logic             clk_en,    // Freezes state when low
  input  wire logic             flush,     // Empties the FIFO
  input  wire logic [WIDTH-1:0] in_data,   // Write data
  input  wire logic             in_valid,  // Write request
  output logic                  in_ready,  // Room available
  output logic      [WIDTH-1:0] out_data,  // Head entry
  output logic                  out_valid, // Head valid
  input  wire logic             out_ready  // Reader takes head
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  // ****************************************
  // Pointer and count update
  // ****************************************
  always_comb begin
    push  = in_valid && in_ready;
    pop   = out_valid && out_ready;
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (flush) begin
      wr_d  = '0;
      rd_d  = '0;
      cnt_d = '0;
    end else begin
      if (push) wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      if (pop) rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      if (push && !pop) cnt_d = cnt_q + 1'b1;
      else if (pop && !push) cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (clk_en) begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
      if (push && !flush) mem_q[wr_q] <= in_data;
    end
  end

  // Honest flags from the count
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
endmodule : latch_fifo
`default_nettype wire

// ===== rtl/serial_latched_sink_driver.sv
// Serial-in shift register, storage register and open-drain sink channels
`timescale 1ns/100ps
`default_nettype none
`include "sink_driver_consts.svh"

// Operation
// - Eight stages shift on rising shift clock
// - Rising latch clock copies stages to storage
// - Low clear zeroes shift, chain, storage and gate flops and empties the queue
// - Storage reaches buffers only while clear high
// - Enable high forces all buffers low
// - Enable low: buffers follow storage directly
// - Bit one sinks current, zero is off
// - Chain output changes on falling shift clock
// - Chain output shows last shift stage
module serial_latched_sink_driver (
  input  wire logic       clk_sys,       // System clock, 100 MHz
  input  wire logic       reset_n,       // Sync reset, active low
  input  wire logic       clk_en,        // Freezes state when low
  input  wire logic       shift_clock,   // Serial shift clock pin
  input  wire logic       latch_clock,   // Storage latch clock pin
  input  wire logic       clear_n,       // Clear pin, active low
  input  wire logic       out_enable_n,  // Output enable pin, active low
  input  wire logic       chain_input,   // Serial data pin
  output logic            chain_output,  // Serial cascade pin
  output logic      [7:0] sink_channel_o,  // Open-drain level, always low
  output logic      [7:0] sink_channel_oe  // High while channel sinks
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0] sck_q;
  logic [2:0] sck_d;
  logic [2:0] lck_q;
  logic [2:0] lck_d;
  logic [2:0] clr_q;
  logic [2:0] clr_d;
  logic [2:0] oen_q;
  logic [2:0] oen_d;
  logic [2:0] din_q;
  logic [2:0] din_d;
  logic       sck_rise;
  logic       sck_fall;
  logic       lck_rise;
  logic       clr_act;
  logic       oen_act;
  logic       din_s;

  // Three stages, changes counted when second and third differ
  always_comb begin
    sck_d = {sck_q[1:0], shift_clock};
    lck_d = {lck_q[1:0], latch_clock};
    clr_d = {clr_q[1:0], clear_n};
    oen_d = {oen_q[1:0], out_enable_n};
    din_d = {din_q[1:0], chain_input};
  end

  // Synchroniser flops; enable pin starts out disabled
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sck_q <= `SD_SYNC_RESET;
      lck_q <= `SD_SYNC_RESET;
      clr_q <= `SD_SYNC_RESET;
      oen_q <= `SD_OEN_SYNC_RESET;
      din_q <= `SD_SYNC_RESET;
    end else if (clk_en) begin
      sck_q <= sck_d;
      lck_q <= lck_d;
      clr_q <= clr_d;
      oen_q <= oen_d;
      din_q <= din_d;
    end
  end

  // Edge and level decode from the settled stages
  always_comb begin
    sck_rise = sck_q[1] && !sck_q[2];
    sck_fall = !sck_q[1] && sck_q[2];
    lck_rise = lck_q[1] && !lck_q[2];
    clr_act  = !clr_q[1];
    oen_act  = !oen_q[1];
    din_s    = din_q[2];
  end

  // ****************************************
  // Shift register
  // ****************************************
  sink_driver_pkg::byte_t shift_q;
  sink_driver_pkg::byte_t shift_d;
  sink_driver_pkg::byte_t shift_feed;
  sink_driver_pkg::byte_t store_q;
  sink_driver_pkg::byte_t store_d;
  sink_driver_pkg::byte_t fifo_data;
  logic                   fifo_valid;
  logic                   chain_q;
  logic                   chain_d;

  // Each stage takes its lower neighbour, stage zero takes the pin
  always_comb begin
    shift_feed = {shift_q[`SD_LAST_STAGE-1:0], din_s};
  end

  // One stage per bit: cleared, moved on a seen rising edge, else held
  for (genvar st = 0; st < `SD_STAGES; st++) begin : g_stage
    logic stage_d;

    // Stage next value
    always_comb begin
      stage_d = shift_q[st];
      if (clr_act) begin
        stage_d = 1'b0;
      end else if (sck_rise) begin
        stage_d = shift_feed[st];
      end
    end

    assign shift_d[st] = stage_d;
  end

  // Shift register flops
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      shift_q <= `SD_RESET_BYTE;
    end else if (clk_en) begin
      shift_q <= shift_d;
    end
  end

  // ****************************************
  // Cascade output
  // ****************************************
  // Last stage moves to the chain pin on a seen falling edge
  always_comb begin
    chain_d = chain_q;
    if (clr_act) begin
      chain_d = 1'b0;
    end else if (sck_fall) begin
      chain_d = shift_q[`SD_LAST_STAGE];
    end
  end

  // Chain output flop
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      chain_q <= 1'b0;
    end else if (clk_en) begin
      chain_q <= chain_d;
    end
  end

  // ****************************************
  // Latch queue
  // ****************************************
  // Snapshots queue toward storage; drained every cycle, so never full
  latch_fifo #(
    .WIDTH (`SD_FIFO_WIDTH),
    .DEPTH (`SD_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .clk_en    (clk_en),
    .flush     (clr_act),
    .in_data   (shift_q),
    .in_valid  (lck_rise && !clr_act),
    .in_ready  (),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (1'b1)
  );

  // ****************************************
  // Storage register
  // ****************************************
  // Head of the queue lands in storage; clear wins
  always_comb begin
    store_d = store_q;
    if (clr_act) begin
      store_d = `SD_RESET_BYTE;
    end else if (fifo_valid) begin
      store_d = fifo_data;
    end
  end

  // Storage flops
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      store_q <= `SD_RESET_BYTE;
    end else if (clk_en) begin
      store_q <= store_d;
    end
  end

  // ****************************************
  // Channel gates and pin drive
  // ****************************************
  // Per channel: storage bit passes only while enabled and not cleared
  for (genvar ch = 0; ch < `SD_CHANNELS; ch++) begin : g_channel
    logic on_d;
    logic on_q;

    // Gate next value
    always_comb begin
      on_d = 1'b0;
      if (!clr_act && oen_act) begin
        on_d = store_d[ch];
      end
    end

    // Gate flop
    always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
        on_q <= 1'b0;
      end else if (clk_en) begin
        on_q <= on_d;
      end
    end

    assign sink_channel_oe[ch] = on_q;
  end

  // Cascade pin straight from its flop
  assign chain_output = chain_q;

  // Open drain only ever pulls low
  assign sink_channel_o = `SD_RESET_BYTE;
endmodule : serial_latched_sink_driver
`default_nettype wire

// ===== dv/sink_driver_props.sv
// Checker for the sink driver ports
`timescale 1ns/100ps
`default_nettype none
module sink_driver_props (
  input wire logic       clk_sys,         // Clock
  input wire logic       reset_n,         // Reset
  input wire logic       clk_en,          // Clock enable
  input wire logic       shift_clock,     // Shift pin
  input wire logic       latch_clock,     // Latch pin
  input wire logic       clear_n,         // Clear pin
  input wire logic       out_enable_n,    // Enable pin
  input wire logic       chain_output,    // Cascade pin
  input wire logic [7:0] sink_channel_o,  // Drain level
  input wire logic [7:0] sink_channel_oe  // Sinking
);
  default clocking cb @(posedge clk_sys); endclocking
  // Frozen cycles are not judged
  default disable iff (!reset_n || !clk_en);
  // Storage path left alone
  sequence s_held;
    (!latch_clock && clear_n && !out_enable_n)[*8];
  endsequence
  a_drain_level_low: assert property (sink_channel_o == 8'h00) else $error("drain level");
  a_disable_holds_off: assert property (out_enable_n[*6] |-> sink_channel_oe == 8'h00) else $error("off");
  a_disable_edge_off: assert property ($rose(out_enable_n) |-> ##[1:6] sink_channel_oe == 8'h00) else $error("edge");
  a_clear_holds_zero: assert property (!clear_n[*7] |-> !chain_output && sink_channel_oe == 8'h00) else $error("clr");
  a_clear_edge_zero: assert property ($fell(clear_n) |-> ##[1:7] !chain_output) else $error("clr edge");
  a_chain_high_still: assert property ((shift_clock && clear_n)[*7] |=> $stable(chain_output)) else $error("hi");
  a_chain_low_still: assert property ((!shift_clock && clear_n)[*7] |=> $stable(chain_output)) else $error("lo");
  a_storage_held: assert property (s_held |=> $stable(sink_channel_oe)) else $error("held");
endmodule : sink_driver_props
bind serial_latched_sink_driver sink_driver_props i_props (.clk_sys, .reset_n, .clk_en, .shift_clock, .latch_clock,
  .clear_n, .out_enable_n, .chain_output, .sink_channel_o, .sink_channel_oe);
`default_nettype wire

// ===== dv/host_model.sv
// Host model driving the serial pins
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input  wire logic clk_sys,     // Clock
  output logic      shift_clock, // Shift pin
  output logic      latch_clock, // Latch pin
  output logic      chain_input  // Data pin
);
  initial begin
    shift_clock = 1'b0;
    latch_clock = 1'b0;
    chain_input = 1'b0;
  end
  // One latch pulse after a frame
  task automatic latch;
    repeat (8) @(negedge clk_sys);
    latch_clock = 1'b1;
    repeat (8) @(negedge clk_sys);
    latch_clock = 1'b0;
  endtask : latch
  // Far bit first, 160 ns shift period
  task automatic send(input logic [7:0] b, input logic do_latch);
    for (int i = 7; i >= 0; i--) begin
      chain_input = b[i];
      repeat (8) @(negedge clk_sys);
      shift_clock = 1'b1;
      repeat (4) @(negedge clk_sys);
      chain_input = ~b[i]; // Hold over
      repeat (4) @(negedge clk_sys);
      shift_clock = 1'b0;
    end
    if (do_latch) latch;
  endtask : send
endmodule : host_model
`default_nettype wire

// ===== dv/testbench.sv
// Bench for the sink driver and FIFO
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic       clk_sys, reset_n, clk_en, clear_n, out_enable_n, shift_clock, latch_clock, chain_input, chain_output;
  logic [7:0] sink_o, sink_oe;
  int         num_errors = 0, n_checks = 0, cyc = 0;
  serial_latched_sink_driver i_dut (.clk_sys, .reset_n, .clk_en, .shift_clock, .latch_clock, .clear_n,
    .out_enable_n, .chain_input, .chain_output, .sink_channel_o(sink_o), .sink_channel_oe(sink_oe));
  host_model i_host (.clk_sys, .shift_clock, .latch_clock, .chain_input);
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      final_report;
    end
  end
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic settle;
    repeat (10) @(negedge clk_sys);
  endtask : settle
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  // Load, shift without latch, then latch
  task automatic t_load;
    i_host.send(8'ha5, 1'b1);
    settle;
    check("sink", 8'ha5, sink_oe);
    check("chain", 8'h01, {7'h00, chain_output});
    i_host.send(8'h3c, 1'b0);
    settle;
    check("held", 8'ha5, sink_oe);
    check("chain", 8'h00, {7'h00, chain_output});
    i_host.latch;
    settle;
    check("sink", 8'h3c, sink_oe);
    check("level", 8'h00, sink_o);
  endtask : t_load
  // Enable off and on, then clear
  task automatic t_gate;
    out_enable_n = 1'b1;
    settle;
    check("off", 8'h00, sink_oe);
    out_enable_n = 1'b0;
    settle;
    check("on", 8'h3c, sink_oe);
    clear_n = 1'b0;
    settle;
    check("clr", 8'h00, sink_oe);
    clear_n = 1'b1;
    i_host.latch;
    settle;
    check("after", 8'h00, sink_oe);
  endtask : t_gate
  // Frames in a row pass the latch queue in order
  task automatic t_queue;
    i_host.send(8'h81, 1'b1);
    settle;
    check("q1", 8'h81, sink_oe);
    check("chain", 8'h01, {7'h00, chain_output});
    i_host.send(8'h7e, 1'b1);
    settle;
    check("q2", 8'h7e, sink_oe);
    check("chain", 8'h00, {7'h00, chain_output});
  endtask : t_queue
  // Clock enable low freezes the outputs
  task automatic t_freeze;
    clk_en = 1'b0;
    out_enable_n = 1'b1;
    settle;
    check("frozen", 8'h7e, sink_oe);
    clk_en = 1'b1;
    settle;
    check("thawed", 8'h00, sink_oe);
    out_enable_n = 1'b0;
    settle;
    check("again", 8'h7e, sink_oe);
  endtask : t_freeze
  initial begin
    {reset_n, clk_en} = 2'b01;
    {clear_n, out_enable_n} = 2'b10;
    repeat (10) @(negedge clk_sys);
    reset_n = 1'b1;
    settle;
    t_load;
    t_gate;
    t_queue;
    t_freeze;
    final_report;
  end
endmodule : testbench
`default_nettype wire
